/* File: logic/ecrr_regs.vh */
// constants for the correction result and event register block
// assumes a 32-bit avalon-mm slave with byte addresses, word aligned
`ifndef ECRR_REGS_VH
`define ECRR_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ECRR_OFF_CORR0      12'h1A0
`define ECRR_OFF_CORR3      12'h1AC
`define ECRR_OFF_IRQ_SET    12'h1B0
`define ECRR_OFF_IRQ_CLR    12'h1B4
`define ECRR_OFF_IRQ_STATE  12'h1B8
`define ECRR_OFF_PEND       12'h1BC
`define ECRR_OFF_PEND_CLR   12'h1C0
`define ECRR_OFF_REVISION   12'h1FC
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ECRR_OFFSET_W       10
`define ECRR_DONE_BIT       0
`define ECRR_VERSION_W      12
`define ECRR_VARIANT_LSB    16
`define ECRR_VARIANT_W      3
`define ECRR_RST_ZERO       32'h00000000
// arbitrary neutral revision values
`define ECRR_VERSION_VAL    12'h0A5
`define ECRR_VARIANT_VAL    3'h0
`endif

/* File: logic/ecrr_event_bit.v */
// one sticky event bit with one-write set and one-write clear inputs
// assumes set and clear are single-cycle pulses on the module clock
`timescale 1ns/100ps
module ecrr_event_bit (
  // clock and reset
  input  wire CLK_SYS,
  input  wire ARST_N,
  // controls
  input  wire set_in,
  input  wire clr_in,
  // state
  output wire bit_out
);
  reg bit_reg; // stored bit
  reg bit_next; // next value
  // set beats clear so a coincident event is never lost
  always @* begin
    bit_next = bit_reg;
    if (clr_in) begin
      bit_next = 1'b0;
    end
    if (set_in) begin
      bit_next = 1'b1;
    end
  end
  // flop, resets to zero
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_reg <= 1'b0;
    end else begin
      bit_reg <= bit_next;
    end
  end
  assign bit_out = bit_reg;
endmodule

/* File: logic/ecrr_top.v */
// correction result and correction-done event registers
// assumes the offset results and done pulse come from the correction engine
// on the same clock; the bus is avalon-mm with waitrequest
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
`include "ecrr_regs.vh"
module ecrr_top (
  // clock and reset
  input  wire        CLK_SYS,
  input  wire        ARST_N,
  // avalon-mm slave
  input  wire [11:0] AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  // correction engine results
  input  wire        CORRECTION_DONE,
  input  wire        FOUR_SYMBOL_CORRECTION_FLAG,
  input  wire [39:0] CORRECTION_OFFSETS,
  // event request
  output wire        IRQ
);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait cycle per access: accept on second cycle of the request
  reg ack_reg; // acknowledge phase flag
  wire req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  wire take = req & ack_reg; // access completes this edge
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end
  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // low byte lane carries bit 0; writes without it do nothing
  wire wr_one = take & AVS_WRITE & AVS_BYTEENABLE[0] & AVS_WRITEDATA[`ECRR_DONE_BIT];
  wire set_mask = wr_one & (AVS_ADDRESS == `ECRR_OFF_IRQ_SET);
  wire clr_mask = wr_one & (AVS_ADDRESS == `ECRR_OFF_IRQ_CLR);
  wire clr_pend = wr_one & (AVS_ADDRESS == `ECRR_OFF_PEND_CLR);
  // ----------------------------------------
  // mask and pending bits
  // ----------------------------------------
  wire mask_bit; // enable state
  wire pend_bit; // sticky pending
  // a set and clear in one write are impossible, distinct addresses
  ecrr_event_bit u_mask (
    .CLK_SYS (CLK_SYS),
    .ARST_N  (ARST_N),
    .set_in  (set_mask),
    .clr_in  (clr_mask),
    .bit_out (mask_bit)
  );
  ecrr_event_bit u_pend (
    .CLK_SYS (CLK_SYS),
    .ARST_N  (ARST_N),
    .set_in  (CORRECTION_DONE),
    .clr_in  (clr_pend),
    .bit_out (pend_bit)
  );
  assign IRQ = pend_bit & mask_bit;
  // ----------------------------------------
  // result capture
  // ----------------------------------------
  // offsets latched at the done pulse so they stay stable for software;
  // the four-symbol flag is captured with them, but no register reads it back
  reg [39:0] offs_reg; // four 10-bit offsets
  reg        flag_reg; // captured four-symbol flag
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      offs_reg <= 40'h0000000000;
      flag_reg <= 1'b0;
    end else if (CORRECTION_DONE) begin
      offs_reg <= CORRECTION_OFFSETS;
      flag_reg <= FOUR_SYMBOL_CORRECTION_FLAG;
    end
  end
  // pick one offset field
  function [9:0] pick_off;
    input [39:0] all;
    input [1:0]  idx;
    begin
      pick_off = all[idx*10 +: 10];
    end
  endfunction
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // flag_reg is kept for debug; offsets read the same either way
  wire       in_corr = (AVS_ADDRESS >= `ECRR_OFF_CORR0) && (AVS_ADDRESS <= `ECRR_OFF_CORR3) &&
                       (AVS_ADDRESS[1:0] == 2'h0);
  wire [1:0] cidx    = AVS_ADDRESS[3:2];
  reg  [31:0] rd_next; // read value
  always @* begin
    rd_next = `ECRR_RST_ZERO;
    if (in_corr) begin
      rd_next = {22'h000000, pick_off(offs_reg, cidx)};
    end else begin
      case (AVS_ADDRESS)
        `ECRR_OFF_IRQ_STATE: rd_next = {31'h00000000, mask_bit};
        `ECRR_OFF_PEND:      rd_next = {31'h00000000, pend_bit};
        `ECRR_OFF_REVISION:  rd_next = {13'h0000, `ECRR_VARIANT_VAL, 4'h0, `ECRR_VERSION_VAL};
        default:             rd_next = `ECRR_RST_ZERO; // write-only and unmapped read zero
      endcase
    end
  end
  // read data registered in the wait cycle, valid when waitrequest drops
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      AVS_READDATA <= `ECRR_RST_ZERO;
    end else if (AVS_READ & ~ack_reg) begin
      AVS_READDATA <= rd_next;
    end
  end
  // everything here runs on the single module clock
  wire unused_flag = flag_reg;
endmodule

/* File: tb/ecrr_props.sv */
// assertions on the ecrr_top ports
// bound into ecrr_top below; one clock, async reset
`timescale 1ns/100ps
module ecrr_props (
  input wire logic CLK_SYS, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CORRECTION_DONE, IRQ,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic [31:0] AVS_WRITEDATA, AVS_READDATA,
  input wire logic [3:0]  AVS_BYTEENABLE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // finished one-writes on lane 0 to set, clear and pending-clear
  wire wd = AVS_WRITE & !AVS_WAITREQUEST & AVS_WRITEDATA[0] & AVS_BYTEENABLE[0];
  wire ws = wd & AVS_ADDRESS == 12'h1B0;
  wire wc = wd & AVS_ADDRESS == 12'h1B4;
  wire wp = wd & AVS_ADDRESS == 12'h1C0;
  wire rc = AVS_READ & !AVS_WAITREQUEST;
  sequence s_en; ws ##2 CORRECTION_DONE; endsequence
  property p_wt; $rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endproperty
  a_wt: assert property (p_wt) else $error("wait");
  property p_up; $rose(IRQ) |-> $past(CORRECTION_DONE | ws); endproperty
  a_up: assert property (p_up) else $error("rise");
  property p_dn; $fell(IRQ) |-> $past(wc | wp); endproperty
  a_dn: assert property (p_dn) else $error("fall");
  property p_ds; wc |=> !IRQ; endproperty
  a_ds: assert property (p_ds) else $error("mask");
  property p_cl; wp & !CORRECTION_DONE |=> !IRQ; endproperty
  a_cl: assert property (p_cl) else $error("pend");
  property p_en; s_en |=> IRQ; endproperty
  a_en: assert property (p_en) else $error("irq");
  property p_rv; rc & AVS_ADDRESS == 12'h1FC |-> AVS_READDATA == 32'h000000A5; endproperty
  a_rv: assert property (p_rv) else $error("rev");
  property p_un; rc & AVS_ADDRESS == 12'h1C4 |-> AVS_READDATA == 32'h0; endproperty
  a_un: assert property (p_un) else $error("hole");
endmodule
bind ecrr_top ecrr_props u_props (.*);

/* File: tb/ecrr_tb_top.sv */
// bench for ecrr_top; msk and pnd model the event bit
`timescale 1ns/100ps
module ecrr_tb_top;
  logic CLK_SYS=0, ARST_N=0, AVS_READ=0, AVS_WRITE=0, CORRECTION_DONE=0, FOUR_SYMBOL_CORRECTION_FLAG=0;
  logic [11:0] AVS_ADDRESS=0;
  logic [31:0] AVS_WRITEDATA=0, AVS_READDATA, q;
  logic [3:0]  AVS_BYTEENABLE=4'hF;
  logic [39:0] CORRECTION_OFFSETS=0;
  logic [63:0] r;
  logic AVS_WAITREQUEST, IRQ, msk=0, pnd=0;
  int failures=0, n_tests=0;
  ecrr_top dut (.*);
  always #20 CLK_SYS = ~CLK_SYS;
  task automatic end_of_test;
    $display("tests %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin failures++; $display("MISMATCH %0t %h %h", $time, g, e); end
  endtask
  // hold the request until waitrequest is low, then release
  // called just after a rising edge; waitrequest is looked at mid-cycle, where it is settled
  task automatic x(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e);
    int n;
    n = 0;
    AVS_ADDRESS <= a; AVS_WRITEDATA <= d; AVS_WRITE <= w; AVS_READ <= !w;
    @(negedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0 && n < 50) begin n++; @(negedge CLK_SYS); end
    if (n >= 50) failures++;
    q = AVS_READDATA;
    @(posedge CLK_SYS) {AVS_WRITE, AVS_READ} <= 2'b0;
    @(posedge CLK_SYS);
    if (!w) chk(q, e);
  endtask
  initial begin #200000; failures++; end_of_test; end
  initial begin
    void'($urandom(65));
    repeat (2) @(posedge CLK_SYS);
    ARST_N <= 1;
    @(posedge CLK_SYS);
    for (int i = 0; i < 4; i++) x(0, {8'h1A, 2'(i), 2'h0}, 0, 0);
    x(0, 12'h1B8, 0, 0);
    x(0, 12'h1C4, 0, 0);
    x(0, 12'h1FC, 0, 32'h000000A5);
    $display("reset test done");
    for (int t = 0; t < 12; t++) begin
      r = {$urandom, $urandom};
      AVS_BYTEENABLE <= r[44:41];
      x(1, 12'h1B0, r[31:0], 0);
      msk |= r[0] & r[41];
      AVS_BYTEENABLE <= 4'hF;
      CORRECTION_OFFSETS <= r[39:0];
      FOUR_SYMBOL_CORRECTION_FLAG <= r[40];
      CORRECTION_DONE <= 1;
      @(posedge CLK_SYS) CORRECTION_DONE <= 0;
      pnd = 1;
      @(negedge CLK_SYS) chk({31'h0, IRQ}, {31'h0, msk & pnd});
      @(posedge CLK_SYS) x(1, 12'h1A0, r[63:32], 0);
      for (int i = 0; i < 4; i++) x(0, {8'h1A, 2'(i), 2'h0}, 0, {22'h0, r[10*i +: 10]});
      x(1, 12'h1C0, r[31:0] & 32'hFFFFFFFE, 0);
      x(0, 12'h1BC, 0, 1);
      x(1, 12'h1C0, 1, 0);
      pnd = 0;
      x(0, 12'h1BC, 0, 0);
      x(1, 12'h1B4, r[63:32], 0);
      msk &= !r[32];
      x(0, 12'h1B8, 0, {31'h0, msk});
      $display("round %0d done", t);
    end
    end_of_test;
  end
endmodule
